// ==== core/prf_pc_unit.sv ====
// program counter register
`timescale 1ns/1ps
`default_nettype none
module prf_pc_unit
   import prf_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire prf_pc_req_s i_req,
   output logic [31:0] o_pc
);
   logic [25:0] pc_q;
   logic [25:0] pc_d;

   // ---------------------------------------------------------------
   // next value
   // ---------------------------------------------------------------
   always_comb begin
      unique case (i_req.op)
         PRF_PC_INCR: pc_d = pc_q + PRF_PC_STEP;
         PRF_PC_LOAD: pc_d = i_req.target[25:0];
         default: pc_d = pc_q;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pc_q <= PRF_PC_RESET;
      end else if (i_ce) begin
         pc_q <= pc_d & PRF_PC_ODD_CLR;
      end
   end

   assign o_pc = {6'h00, pc_q};

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb_pc @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   a_pc_even: assert property (
      o_pc[0] == 1'b0)
      else $error("pc odd");
   a_pc_upper_zero: assert property (
      o_pc[31:26] == 6'h00)
      else $error("pc upper set");
   a_pc_wrap: assert property (
      i_ce && i_req.op == PRF_PC_INCR |=>
      pc_q == (($past(pc_q) + PRF_PC_STEP) & PRF_PC_ODD_CLR))
      else $error("pc increment wrong");
   a_pc_hold: assert property (
      !i_ce |=> $stable(pc_q))
      else $error("pc moved while frozen");
endmodule
`default_nettype wire

// ==== core/prf_pkg.sv ====
// package for the program register file
package prf_pkg;
   localparam int PRF_DATA_W = 32;
   localparam int PRF_NUM_REGS = 32;
   localparam int PRF_IDX_W = 5;
   localparam int PRF_PC_W = 26;
   localparam logic [4:0] PRF_ZERO_IDX = 5'h00;
   localparam logic [4:0] PRF_EBP_IDX = 5'h1e;
   localparam logic [31:0] PRF_ZERO_WORD = 32'h0000_0000;
   localparam logic [25:0] PRF_PC_RESET = 26'h000_0000;
   localparam logic [25:0] PRF_PC_STEP = 26'h000_0004;
   localparam logic [25:0] PRF_PC_ODD_CLR = 26'h3ff_fffe;

   typedef enum logic [1:0] {
      PRF_PC_HOLD,
      PRF_PC_INCR,
      PRF_PC_LOAD
   } prf_pc_op_e;

   typedef struct packed {
      logic en;
      logic [4:0] idx;
      logic [31:0] data;
   } prf_wr_s;

   typedef struct packed {
      prf_pc_op_e op;
      logic [31:0] target;
   } prf_pc_req_s;
endpackage

// ==== core/prf_regfile.sv ====
// program register file top: general registers and program counter
`timescale 1ns/1ps
`default_nettype none
module prf_regfile
   import prf_pkg::*;
#(
   parameter int NUM_REGS = PRF_NUM_REGS
) (
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire logic i_ce,
   input wire logic [4:0] i_rd_a_idx,
   input wire logic [4:0] i_rd_b_idx,
   input wire logic i_short_format_access,
   input wire prf_wr_s i_wr,
   input wire prf_pc_req_s i_pc_req,
   output logic [31:0] o_rd_a_data,
   output logic [31:0] o_rd_b_data,
   output logic [31:0] o_element_base_pointer,
   output logic [31:0] o_base_data,
   output logic [31:0] o_pc
);
   logic rst_s1_q;
   logic rst_n_q;
   logic [31:0] regs_q [NUM_REGS];

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   function automatic logic [31:0] read_reg(input logic [4:0] idx);
      if (idx == PRF_ZERO_IDX) begin
         read_reg = PRF_ZERO_WORD;
      end else begin
         read_reg = regs_q[idx];
      end
   endfunction

   function automatic logic wr_taken(input prf_wr_s w, input logic ce);
      wr_taken = ce && w.en && (w.idx != PRF_ZERO_IDX);
   endfunction

   // ---------------------------------------------------------------
   // register write
   // ---------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_q[i] <= PRF_ZERO_WORD;
         end
      end else if (wr_taken(i_wr, i_ce)) begin
         regs_q[i_wr.idx] <= i_wr.data;
      end
   end

   // ---------------------------------------------------------------
   // read ports
   // ---------------------------------------------------------------
   // processes, not assigns, so array updates wake the reads
   always_comb begin
      o_rd_a_data = read_reg(i_rd_a_idx);
   end

   always_comb begin
      o_rd_b_data = read_reg(i_rd_b_idx);
   end

   always_comb begin
      o_element_base_pointer = read_reg(PRF_EBP_IDX);
   end

   always_comb begin
      if (i_short_format_access) begin
         o_base_data = read_reg(PRF_EBP_IDX);
      end else begin
         o_base_data = read_reg(i_rd_a_idx);
      end
   end

   prf_pc_unit u_pc (
      .i_clk(i_sys_clk),
      .i_rst_n(rst_n_q),
      .i_ce(i_ce),
      .i_req(i_pc_req),
      .o_pc(o_pc)
   );

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb_rf @(posedge i_sys_clk);
   endclocking
   default disable iff (!rst_n_q);

   sequence s_write_zero;
      i_ce && i_wr.en && i_wr.idx == PRF_ZERO_IDX;
   endsequence

   sequence s_write_taken;
      wr_taken(i_wr, i_ce);
   endsequence

   sequence s_frozen_write;
      !i_ce && i_wr.en;
   endsequence

   sequence s_pc_load;
      i_ce && i_pc_req.op == PRF_PC_LOAD;
   endsequence

   sequence s_pc_idle;
      i_ce && i_pc_req.op == PRF_PC_HOLD;
   endsequence

   // ---------------------------------------------------------------
   // zero register
   // ---------------------------------------------------------------
   a_zero_reads: assert property (
      i_rd_a_idx == PRF_ZERO_IDX |-> o_rd_a_data == PRF_ZERO_WORD)
      else $error("zero register nonzero");

   a_zero_reads_b: assert property (
      i_rd_b_idx == PRF_ZERO_IDX |-> o_rd_b_data == PRF_ZERO_WORD)
      else $error("zero register nonzero on port b");

   a_zero_write_drop: assert property (
      s_write_zero ##1 i_rd_b_idx == PRF_ZERO_IDX |->
      o_rd_b_data == PRF_ZERO_WORD)
      else $error("write to zero register took effect");

   a_zero_cell_clear: assert property (
      s_write_zero |=> regs_q[PRF_ZERO_IDX] == PRF_ZERO_WORD)
      else $error("zero register cell written");

   // ---------------------------------------------------------------
   // general registers
   // ---------------------------------------------------------------
   a_write_lands: assert property (
      s_write_taken |=>
      regs_q[$past(i_wr.idx)] == $past(i_wr.data))
      else $error("register write lost");

   a_frozen_write: assert property (
      s_frozen_write |=>
      regs_q[$past(i_wr.idx)] == $past(regs_q[i_wr.idx]))
      else $error("register written while frozen");

   a_rd_a_value: assert property (
      i_rd_a_idx != PRF_ZERO_IDX |-> o_rd_a_data == regs_q[i_rd_a_idx])
      else $error("port a read wrong");

   a_rd_b_value: assert property (
      i_rd_b_idx != PRF_ZERO_IDX |-> o_rd_b_data == regs_q[i_rd_b_idx])
      else $error("port b read wrong");

   a_write_isolated: assert property (
      s_write_taken ##0 i_wr.idx != PRF_EBP_IDX |=>
      $stable(o_element_base_pointer))
      else $error("base pointer disturbed by other write");

   // ---------------------------------------------------------------
   // base pointer
   // ---------------------------------------------------------------
   a_short_base: assert property (
      i_short_format_access |-> o_base_data == o_element_base_pointer)
      else $error("short access base wrong");

   a_ebp_value: assert property (
      o_element_base_pointer == regs_q[PRF_EBP_IDX])
      else $error("base pointer not register 30");

   a_base_long: assert property (
      !i_short_format_access |-> o_base_data == o_rd_a_data)
      else $error("long access base wrong");

   // ---------------------------------------------------------------
   // program counter
   // ---------------------------------------------------------------
   a_pc_load: assert property (
      s_pc_load |=>
      o_pc == {6'h00, $past(i_pc_req.target[25:0]) & PRF_PC_ODD_CLR})
      else $error("pc load wrong");

   a_pc_idle: assert property (
      s_pc_idle |=> $stable(o_pc))
      else $error("pc moved on hold");

   a_pc_frozen: assert property (
      !i_ce |=> $stable(o_pc))
      else $error("pc output moved while frozen");

   a_pc_width: assert property (
      o_pc[31:26] == 6'h00 && o_pc[0] == 1'b0)
      else $error("pc outside its space");
endmodule
`default_nettype wire

// ==== verif/prf_pipe_model.sv ====
// pipeline-side request model for the register file
`timescale 1ns/1ps
`default_nettype none
module prf_pipe_model
   import prf_pkg::*;
(
   input wire logic i_sys_clk,
   output var prf_wr_s o_wr,
   output var prf_pc_req_s o_pc_req
);
   initial begin
      o_wr = '0;
      o_pc_req = '{PRF_PC_HOLD, 32'h0};
   end
   // one-cycle write, then idle with the data scrambled
   task automatic put_wr(input logic [4:0] idx, input logic [31:0] d);
      o_wr = '{1'b1, idx, d};
      @(posedge i_sys_clk) #1;
      o_wr = '{1'b0, ~idx, ~d};
   endtask
   task automatic put_pc(input prf_pc_op_e op, input logic [31:0] t);
      o_pc_req = '{op, t};
      @(posedge i_sys_clk) #1;
      o_pc_req = '{PRF_PC_HOLD, ~t};
   endtask
endmodule
`default_nettype wire

// ==== verif/test_prf_regfile.sv ====
// self-checking bench for the program register file
`timescale 1ns/1ps
`default_nettype none
module test_prf_regfile;
   import prf_pkg::*;
   logic i_sys_clk = 0, i_reset_n = 0, i_ce = 1, short_acc = 0;
   logic [4:0] ra = '0, rb = '0;
   prf_wr_s wr;
   prf_pc_req_s pcr;
   logic [31:0] rd_a, rd_b, ebp, base, pc;
   int fails = 0, cmp_count = 0;
   always #10 i_sys_clk = ~i_sys_clk;
   prf_pipe_model pipe (.i_sys_clk(i_sys_clk), .o_wr(wr), .o_pc_req(pcr));
   prf_regfile dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
      .i_ce(i_ce), .i_rd_a_idx(ra), .i_rd_b_idx(rb),
      .i_short_format_access(short_acc), .i_wr(wr), .i_pc_req(pcr),
      .o_rd_a_data(rd_a), .o_rd_b_data(rd_b),
      .o_element_base_pointer(ebp), .o_base_data(base), .o_pc(pc));
   task automatic chk(input string n, input logic [31:0] e, s);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   function automatic logic [31:0] pat(input int i);
      return 32'ha5c3_0000 | 32'(i * 3);
   endfunction
   task automatic t_regs;
      for (int i = 0; i < 32; i++) pipe.put_wr(5'(i), pat(i) | 32'h1);
      for (int i = 0; i < 32; i++) begin
         ra = 5'(i);
         rb = 5'(31 - i);
         #1;
         chk("rd_a", i == 0 ? PRF_ZERO_WORD : pat(i) | 32'h1, rd_a);
         chk("rd_b", i == 31 ? PRF_ZERO_WORD : pat(31 - i) | 32'h1, rd_b);
      end
      $display("test regs done");
   endtask
   task automatic t_base;
      ra = 5'h07;
      short_acc = 1;
      #1;
      chk("base", pat(30) | 32'h1, base);
      chk("ebp", pat(30) | 32'h1, ebp);
      short_acc = 0;
      #1;
      chk("base_long", pat(7) | 32'h1, base);
      ra = PRF_ZERO_IDX;
      #1;
      chk("zero_reg", PRF_ZERO_WORD, rd_a);
      $display("test base done");
   endtask
   task automatic t_pc;
      chk("pc_reset", 32'h0, pc);
      pipe.put_pc(PRF_PC_LOAD, 32'hffff_ffff);
      chk("pc_load", 32'h03ff_fffe, pc);
      pipe.put_pc(PRF_PC_INCR, 32'h0);
      chk("pc_wrap", 32'h0000_0002, pc);
      pipe.put_pc(PRF_PC_LOAD, 32'hfc00_0005);
      chk("pc_odd", 32'h0000_0004, pc);
      $display("test pc done");
   endtask
   task automatic t_freeze;
      @(posedge i_sys_clk) #1;
      i_ce = 0;
      pipe.put_wr(5'h05, 32'h1234_5678);
      pipe.put_pc(PRF_PC_INCR, 32'h0);
      ra = 5'h05;
      #1;
      chk("frz_reg", pat(5) | 32'h1, rd_a);
      chk("frz_pc", 32'h0000_0004, pc);
      i_ce = 1;
      pipe.put_pc(PRF_PC_INCR, 32'h0);
      chk("pc_incr", 32'h0000_0008, pc);
      $display("test freeze done");
   endtask
   task automatic t_zero;
      pipe.put_wr(PRF_ZERO_IDX, 32'hffff_ffff);
      ra = PRF_ZERO_IDX;
      #1;
      chk("zero_wr", PRF_ZERO_WORD, rd_a);
      $display("test zero done");
   endtask
   initial begin
      #100000;
      fails++;
      tally_and_finish();
   end
   initial begin
      repeat (16) @(posedge i_sys_clk);
      #1 i_reset_n = 1;
      repeat (3) @(posedge i_sys_clk);
      #1;
      t_pc();
      t_regs();
      t_zero();
      t_base();
      t_freeze();
      tally_and_finish();
   end
endmodule
`default_nettype wire
